// [src/output_stage_defines.svh]
// Register offsets, field positions, reset values for the output stage control bank
`ifndef OUTPUT_STAGE_DEFINES_SVH
`define OUTPUT_STAGE_DEFINES_SVH
`define OFS_HP_DRIVER_CTRL 7'h26
`define OFS_RESERVED_BLOCK 7'h27
`define OFS_OUT_STAGE_CTRL 7'h28
`define OFS_ROUTE_VOL_LINK 7'h29
`define OFS_LEFT_VOLUME 7'h2B
`define OFS_RIGHT_VOLUME 7'h2C
`define HPD_MODE_MSB 5
`define HPD_MODE_LSB 3
`define HPD_SC_EN_BIT 2
`define HPD_SC_MODE_BIT 1
`define OSC_CM_MSB 7
`define OSC_CM_LSB 6
`define OSC_STEP_MSB 1
`define OSC_STEP_LSB 0
`define RVL_LEFT_MSB 7
`define RVL_LEFT_LSB 6
`define RVL_RIGHT_MSB 5
`define RVL_RIGHT_LSB 4
`define RVL_LINK_MSB 1
`define RVL_LINK_LSB 0
`define VOL_MUTE_BIT 7
`define HPD_WRITE_MASK 8'h3E
`define OSC_WRITE_MASK 8'hFF
`define RVL_WRITE_MASK 8'hFF
`define HPD_RESET 8'h00
`define OSC_RESET 8'h00
`define RVL_RESET 8'h00
`define VOL_RESET 8'h80
`define RESERVED_READ 8'h00
`endif

// [src/output_stage_pkg.sv]
// Types shared by the output stage control bank
package output_stage_pkg;
    typedef enum logic [2:0] {
        RCOM_INV_MAIN = 3'h0,
        RCOM_MID_LEVEL = 3'h1,
        RCOM_SINGLE_ENDED = 3'h2,
        RCOM_INV_LEFT_COMMON = 3'h3,
        RCOM_EXT_FEEDBACK = 3'h4
    } rcom_mode_t;
    typedef enum logic [1:0] {
        STEP_PER_SAMPLE = 2'h0,
        STEP_PER_TWO = 2'h1,
        STEP_OFF = 2'h2
    } step_rate_t;
    typedef enum logic [1:0] {
        PATH_FIRST = 2'h0,
        PATH_THIRD = 2'h1,
        PATH_SECOND = 2'h2
    } dac_path_t;
    typedef struct packed {
        logic mute;
        logic [6:0] atten;
    } dac_volume_t;
    typedef struct packed {
        logic write_en;
        logic [6:0] addr;
        logic [7:0] wdata;
    } reg_write_t;
    typedef struct packed {
        logic [2:0] rcom_mode;
        logic short_prot_en;
        logic short_prot_shutdown;
        logic short_prot_limit;
        logic [1:0] cm_level;
        logic [1:0] step_rate;
        logic [1:0] left_route;
        logic [1:0] right_route;
    } analog_ctrl_t;
endpackage

// [src/output_stage_control_regs.sv]
// Output stage control register bank of the audio codec
`timescale 1ns/1ps
`include "output_stage_defines.svh"
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
module output_stage_control_regs (
    input wire logic clk, // 25 MHz control clock
    input wire logic arst_n, // Asynchronous reset, active low
    input output_stage_pkg::reg_write_t wr, // Register write from control bus
    input wire logic [6:0] rd_addr, // Register read address
    output logic [7:0] rd_data, // Read data, registered
    input wire logic sample_period_tick, // One-cycle pulse per sample period
    output output_stage_pkg::analog_ctrl_t analog_ctrl, // Fields to analog network
    output output_stage_pkg::dac_volume_t left_volume_applied, // Left channel gain used
    output output_stage_pkg::dac_volume_t right_volume_applied // Right channel gain used
);
    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    logic [7:0] hp_driver_control;
    logic [7:0] output_stage_control;
    logic [7:0] dac_route_and_volume_link;
    logic [7:0] left_volume;
    logic [7:0] right_volume;
    logic [1:0] link_applied;

    // Masked write merge: read-only bits keep their stored value
    function automatic logic [7:0] merge_write(input logic [7:0] old, input logic [7:0] data,
                                               input logic [7:0] mask);
        merge_write = (old & ~mask) | (data & mask);
    endfunction

    // Picks the volume a channel obeys given the link code
    function automatic output_stage_pkg::dac_volume_t pick_volume(input logic follow_other,
                                                                  input logic [7:0] own,
                                                                  input logic [7:0] other);
        pick_volume = follow_other ? other : own;
    endfunction

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    // Writes to the reserved register select nothing, so they are dropped
    wire hit_hpd = wr.write_en && (wr.addr == `OFS_HP_DRIVER_CTRL);
    wire hit_osc = wr.write_en && (wr.addr == `OFS_OUT_STAGE_CTRL);
    wire hit_rvl = wr.write_en && (wr.addr == `OFS_ROUTE_VOL_LINK);
    wire hit_lv = wr.write_en && (wr.addr == `OFS_LEFT_VOLUME);
    wire hit_rv = wr.write_en && (wr.addr == `OFS_RIGHT_VOLUME);

    // Driver control: only D5..D1 are writable, D7,D6,D0 stay zero
    wire [7:0] next_hpd = merge_write(hp_driver_control, wr.wdata, `HPD_WRITE_MASK);
    wire [7:0] next_osc = merge_write(output_stage_control, wr.wdata, `OSC_WRITE_MASK);
    wire [7:0] next_rvl = merge_write(dac_route_and_volume_link, wr.wdata, `RVL_WRITE_MASK);

    // ------------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hp_driver_control <= `HPD_RESET;
            output_stage_control <= `OSC_RESET;
            dac_route_and_volume_link <= `RVL_RESET;
            left_volume <= `VOL_RESET;
            right_volume <= `VOL_RESET;
        end else begin
            if (hit_hpd) hp_driver_control <= next_hpd;
            if (hit_osc) output_stage_control <= next_osc;
            if (hit_rvl) dac_route_and_volume_link <= next_rvl;
            if (hit_lv) left_volume <= wr.wdata;
            if (hit_rv) right_volume <= wr.wdata;
        end
    end

    // Link code moves only on a sample tick so no sample sees half a change
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            link_applied <= 2'h0;
        end else if (sample_period_tick) begin
            link_applied <= dac_route_and_volume_link[`RVL_LINK_MSB:`RVL_LINK_LSB];
        end
    end

    // ------------------------------------------------------------------------
    // Volume selection and field outputs
    // ------------------------------------------------------------------------
    // Codes 00 and 11 both leave the channels independent
    wire left_follows_right = (link_applied == 2'h1);
    wire right_follows_left = (link_applied == 2'h2);
    wire [7:0] left_sel = pick_volume(left_follows_right, left_volume, right_volume);
    wire [7:0] right_sel = pick_volume(right_follows_left, right_volume, left_volume);
    wire sc_en = hp_driver_control[`HPD_SC_EN_BIT];
    wire sc_mode = hp_driver_control[`HPD_SC_MODE_BIT];

    // Outputs are stored bits with light gating; protection mode only counts when enabled
    always_comb begin
        analog_ctrl.rcom_mode = hp_driver_control[`HPD_MODE_MSB:`HPD_MODE_LSB];
        analog_ctrl.short_prot_en = sc_en;
        analog_ctrl.short_prot_shutdown = sc_en & sc_mode;
        analog_ctrl.short_prot_limit = sc_en & ~sc_mode;
        analog_ctrl.cm_level = output_stage_control[`OSC_CM_MSB:`OSC_CM_LSB];
        analog_ctrl.step_rate = output_stage_control[`OSC_STEP_MSB:`OSC_STEP_LSB];
        analog_ctrl.left_route = dac_route_and_volume_link[`RVL_LEFT_MSB:`RVL_LEFT_LSB];
        analog_ctrl.right_route = dac_route_and_volume_link[`RVL_RIGHT_MSB:`RVL_RIGHT_LSB];
        left_volume_applied = left_sel;
        right_volume_applied = right_sel;
    end

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    // Unmapped and reserved addresses read zero
    wire [7:0] rd_mux = (rd_addr == `OFS_HP_DRIVER_CTRL) ? hp_driver_control :
                        (rd_addr == `OFS_RESERVED_BLOCK) ? `RESERVED_READ :
                        (rd_addr == `OFS_OUT_STAGE_CTRL) ? output_stage_control :
                        (rd_addr == `OFS_ROUTE_VOL_LINK) ? dac_route_and_volume_link :
                        (rd_addr == `OFS_LEFT_VOLUME) ? left_volume :
                        (rd_addr == `OFS_RIGHT_VOLUME) ? right_volume : 8'h00;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= rd_mux;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    sequence s_link_write;
        hit_rvl ##1 !sample_period_tick;
    endsequence

    chk_reserved_bit_zero: assert property (@(posedge clk) disable iff (!arst_n)
        hp_driver_control[0] == 1'b0 && hp_driver_control[7:6] == 2'h0)
        else $error("driver control reserved bits not zero");

    chk_reserved_reads_zero: assert property (@(posedge clk) disable iff (!arst_n)
        rd_addr == `OFS_RESERVED_BLOCK |=> rd_data == 8'h00)
        else $error("reserved register read nonzero");

    chk_rcom_mode_follows: assert property (@(posedge clk) disable iff (!arst_n)
        hit_hpd |=> analog_ctrl.rcom_mode == $past(wr.wdata[5:3]))
        else $error("right common mode did not take write");

    chk_prot_enable_gate: assert property (@(posedge clk) disable iff (!arst_n)
        !analog_ctrl.short_prot_en |-> !analog_ctrl.short_prot_shutdown && !analog_ctrl.short_prot_limit)
        else $error("protection active while disabled");

    chk_prot_mode_select: assert property (@(posedge clk) disable iff (!arst_n)
        hit_hpd && wr.wdata[2] |=> analog_ctrl.short_prot_shutdown == $past(wr.wdata[1]))
        else $error("protection mode wrong");

    chk_cm_level_write: assert property (@(posedge clk) disable iff (!arst_n)
        hit_osc |=> analog_ctrl.cm_level == $past(wr.wdata[7:6]) && analog_ctrl.step_rate == $past(wr.wdata[1:0]))
        else $error("stage control fields did not take write");

    chk_route_write: assert property (@(posedge clk) disable iff (!arst_n)
        hit_rvl |=> analog_ctrl.left_route == $past(wr.wdata[7:6]) && analog_ctrl.right_route == $past(wr.wdata[5:4]))
        else $error("route fields did not take write");

    chk_link_waits_tick: assert property (@(posedge clk) disable iff (!arst_n)
        s_link_write |=> $stable(link_applied))
        else $error("link changed without sample tick");

    chk_left_follows_right: assert property (@(posedge clk) disable iff (!arst_n)
        link_applied == 2'h1 |-> left_volume_applied == right_volume)
        else $error("left not following right volume");

    chk_right_follows_left: assert property (@(posedge clk) disable iff (!arst_n)
        link_applied == 2'h2 |-> right_volume_applied == left_volume)
        else $error("right not following left volume");

    chk_link_independent: assert property (@(posedge clk) disable iff (!arst_n)
        (link_applied == 2'h0 || link_applied == 2'h3) |->
            left_volume_applied == left_volume && right_volume_applied == right_volume)
        else $error("independent volumes crossed");

    // A tick copies the stored link code; without one the applied code must hold
    chk_link_takes_tick: assert property (@(posedge clk) disable iff (!arst_n)
        sample_period_tick |=> link_applied == $past(dac_route_and_volume_link[`RVL_LINK_MSB:`RVL_LINK_LSB]))
        else $error("link not taken at sample tick");

    chk_link_hold_still: assert property (@(posedge clk) disable iff (!arst_n)
        !sample_period_tick |=> $stable(link_applied))
        else $error("link moved between sample ticks");

    // Volume registers are not tick gated; they take the write at once
    chk_left_volume_write: assert property (@(posedge clk) disable iff (!arst_n)
        hit_lv |=> left_volume == $past(wr.wdata))
        else $error("left volume did not take write");

    chk_right_volume_write: assert property (@(posedge clk) disable iff (!arst_n)
        hit_rv |=> right_volume == $past(wr.wdata))
        else $error("right volume did not take write");

    chk_prot_enable_write: assert property (@(posedge clk) disable iff (!arst_n)
        hit_hpd |=> analog_ctrl.short_prot_en == $past(wr.wdata[`HPD_SC_EN_BIT]))
        else $error("protection enable did not take write");

    chk_prot_limit_select: assert property (@(posedge clk) disable iff (!arst_n)
        hit_hpd && wr.wdata[`HPD_SC_EN_BIT] |=> analog_ctrl.short_prot_limit == !$past(wr.wdata[`HPD_SC_MODE_BIT]))
        else $error("current limit mode wrong");

    // Reserved or unmapped writes must leave every register alone
    chk_stray_write_dropped: assert property (@(posedge clk) disable iff (!arst_n)
        wr.write_en && !hit_hpd && !hit_osc && !hit_rvl && !hit_lv && !hit_rv |=>
            $stable(hp_driver_control) && $stable(output_stage_control) && $stable(dac_route_and_volume_link) &&
            $stable(left_volume) && $stable(right_volume))
        else $error("stray write changed a register");
endmodule

// [bench/host_model.sv]
// Host model: control bus write and read cycles
`timescale 1ns/1ps
module host_model (
    input wire logic clk, // Control clock
    output output_stage_pkg::reg_write_t wr, // Write request
    output logic [6:0] rd_addr, // Read address
    input wire logic [7:0] rd_data // Registered read data
);
    // Idle at time zero
    initial begin
        wr = '0;
        rd_addr = 7'h00;
    end
    // One-cycle write; idle fields inverted so stale data never passes
    // Callers send no reserved codes and nothing to 0x27
    task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = '{write_en: 1'b1, addr: a, wdata: d};
        @(negedge clk);
        wr = '{write_en: 1'b0, addr: ~a, wdata: ~d};
    endtask
    // Address held over the sampling edge, data taken a cycle later
    task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
        @(negedge clk);
        rd_addr = a;
        @(negedge clk);
        d = rd_data;
    endtask
endmodule

// [bench/tb_top.sv]
// Testbench for the output stage control bank
`timescale 1ns/1ps
module tb_top;
    logic clk;
    logic arst_n;
    logic tick;
    output_stage_pkg::reg_write_t wr;
    logic [6:0] rd_addr;
    logic [7:0] rd_data;
    output_stage_pkg::analog_ctrl_t ac;
    output_stage_pkg::dac_volume_t lv;
    output_stage_pkg::dac_volume_t rv;
    logic [7:0] hv;
    logic [7:0] ov;
    logic [7:0] lk;
    int miscompares = 0;
    int checks_done = 0;
    output_stage_control_regs dut (.clk(clk), .arst_n(arst_n), .wr(wr), .rd_addr(rd_addr), .rd_data(rd_data),
        .sample_period_tick(tick), .analog_ctrl(ac), .left_volume_applied(lv), .right_volume_applied(rv));
    host_model host (.clk(clk), .wr(wr), .rd_addr(rd_addr), .rd_data(rd_data));
    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Compare helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.read_reg(a, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask
    // Write, then compare decoded fields against shadow copies
    task automatic wreg(input logic [6:0] a, input logic [7:0] d);
        host.write_reg(a, d);
        if (a == 7'h26) hv = d & 8'h3E;
        if (a == 7'h28) ov = d;
        if (a == 7'h29) lk = d;
        chk({2'b00, ac}, {2'b00, hv[5:3], hv[2], hv[2] & hv[1], hv[2] & ~hv[1], ov[7:6], ov[1:0], lk[7:6], lk[5:4]});
    endtask
    // Link code change must wait for the tick
    task automatic link(input logic [1:0] c, input logic [15:0] prev, input logic [15:0] exp);
        wreg(7'h29, {lk[7:2], c});
        repeat (3) @(negedge clk);
        chk({lv, rv}, prev);
        tick = 1'b1;
        @(negedge clk);
        tick = 1'b0;
        chk({lv, rv}, exp);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        #200000;
        miscompares++;
        tally_and_finish();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        arst_n = 1'b0;
        tick = 1'b0;
        hv = 8'h00;
        ov = 8'h00;
        lk = 8'h00;
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        chk({2'b00, ac}, 16'h0000);
        chk({lv, rv}, 16'h8080);
        for (int i = 'h26; i <= 'h2C; i++) begin
            rdchk(7'(i), (i >= 'h2B) ? 8'h80 : 8'h00);
        end
        $display("test reset done");
        // Every driver mode, all protection enable and mode pairs
        for (int m = 0; m < 5; m++) begin
            wreg(7'h26, {2'b00, 3'(m), 3'(m % 4) << 1});
            rdchk(7'h26, {2'b00, 3'(m), 3'(m % 4) << 1});
        end
        $display("test driver control done");
        for (int i = 0; i < 12; i++) begin
            wreg(7'h28, {2'(i % 4), 4'h0, 2'(i % 3)});
            rdchk(7'h28, {2'(i % 4), 4'h0, 2'(i % 3)});
        end
        $display("test output stage done");
        for (int i = 0; i < 3; i++) begin
            wreg(7'h29, {2'(i), 2'(2 - i), 4'h0});
            rdchk(7'h29, {2'(i), 2'(2 - i), 4'h0});
        end
        // Unmapped write is dropped and touches nothing
        wreg(7'h30, 8'h5A);
        rdchk(7'h30, 8'h00);
        rdchk(7'h29, lk);
        $display("test routing done");
        wreg(7'h2B, 8'h85);
        wreg(7'h2C, 8'h1A);
        chk({lv, rv}, 16'h851A);
        link(2'h1, 16'h851A, 16'h1A1A);
        link(2'h2, 16'h1A1A, 16'h8585);
        link(2'h3, 16'h8585, 16'h851A);
        link(2'h0, 16'h851A, 16'h851A);
        $display("test volume link done");
        tally_and_finish();
    end
endmodule
